//--- rtl/ccs_ctrl.sv
// Game-flow controller: coins, credits, start, misses, refills and high score
`timescale 1ns/1ps
module ccs_ctrl
  import ccs_pkg::*;
#(
  parameter int FREEZE_CYCLES = FREEZE_CYC
)(
  input  wire logic        sys_clk,        // 20 MHz system clock
  input  wire logic        rst_n,          // Synchronous reset, active low
  input  wire logic        coin_a,         // Left coin switch, high when closed
  input  wire logic        coin_b,         // Right coin switch, high when closed
  input  wire logic        slam,           // Slam switch, high when closed
  input  wire logic        start_blk,      // Black start button
  input  wire logic        start_wht,      // White start button
  input  wire logic [1:0]  cost_sel,       // Game cost option
  input  wire logic [2:0]  miss_limit,     // Misses per play
  input  wire logic        hs_clear,       // High-score clear button
  input  wire logic [1:0]  fire,           // Fire request per aircraft, [0] black
  input  wire logic [1:0]  bomb_done,      // Bomb landed and exploded, per aircraft
  input  wire logic [1:0]  miss_evt,       // Miss pulse per aircraft
  input  wire logic [1:0]  field_clear,    // All targets hit, per player
  input  wire logic [1:0]  score_inc,      // Score point pulse per aircraft
  output logic             lockout_coil,   // Coil energized, coins to box
  output logic             start_lamp,     // Start button lamp
  output logic [2:0]       credits,        // Displayed credits
  output logic [1:0]       mode,           // Current mode (state code)
  output logic [1:0]       human,          // Human-controlled aircraft mask
  output logic [1:0]       bomb_go,        // Bomb release pulse per aircraft
  output logic             refill,         // Refill target field pulse
  output logic             show_misses,    // Misses shown in place of high score
  output logic [5:0]       misses_left,    // {white, black} misses left
  output logic [31:0]      scores,         // {white, black} last game scores
  output logic [31:0]      high_scores     // {white, black} high scores
);

  // Credits from coins held and cost setting
  function automatic logic [2:0] credit_of(input logic [2:0] c, input logic [1:0] s,
                                            input logic [2:0] plays);
    logic [3:0] r;
    r = 4'h0;
    case (s)
      COST_ONE_COIN:   r = {1'b0, c};
      COST_TWO_COIN:   r = {2'b00, c[2:1]};
      COST_TWO_PLAYER: r = {c, 1'b0};
      default:         r = 4'h2;
    endcase
    r = r + {1'b0, plays};
    credit_of = (r > 4'h7) ? 3'h7 : r[2:0];
  endfunction

  // Debounce: input must hold steady DEB_CYC cycles; returns rising event
  logic [4:0] raw;
  logic [4:0] deb_q, deb_d;
  logic [3:0] cnt_q [5];
  logic [3:0] cnt_d [5];
  logic [4:0] evt;
  assign raw = {hs_clear, start_wht, start_blk, coin_b | coin_a, slam};
  always_comb
  begin
    deb_d = deb_q;
    evt   = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      cnt_d[i] = 4'h0;
      if (raw[i] != deb_q[i])
      begin
        cnt_d[i] = cnt_q[i] + 4'h1;
        if (cnt_q[i] == 4'(DEB_CYC - 1))
        begin
          cnt_d[i] = 4'h0;
          deb_d[i] = raw[i];
          evt[i]   = raw[i];
        end
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      deb_q <= 5'h00;
      for (int i = 0; i < 5; i++) cnt_q[i] <= 4'h0;
    end
    else
    begin
      deb_q <= deb_d;
      for (int i = 0; i < 5; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  // Events; coin OR merges both slots, slam gates it
  logic coin_ev, sb_ev, sw_ev, hs_ev;
  assign coin_ev = evt[1] & ~deb_q[0] & ~slam;
  assign sb_ev   = evt[2];
  assign sw_ev   = evt[3];
  assign hs_ev   = evt[4];

  // Game flow state
  ccs_state_t  st_q, st_d;
  logic [2:0]  coins_q, coins_d;
  logic [2:0]  plays_q, plays_d;
  logic [26:0] frz_q, frz_d;
  logic [1:0]  hum_q, hum_d;
  logic [2:0]  mb_q, mb_d, mw_q, mw_d;
  logic [2:0]  refill_q, refill_d;
  logic [1:0]  bbusy_q, bbusy_d;
  logic [15:0] sc_q [2];
  logic [15:0] sc_d [2];
  logic [15:0] hs_q [2];
  logic [15:0] hs_d [2];
  logic [2:0]  cred;
  logic        done_b, done_w;
  assign cred   = credit_of(coins_q, cost_sel, plays_q);
  assign done_b = ~hum_q[0] | (mb_q == 3'h0);
  assign done_w = ~hum_q[1] | (mw_q == 3'h0);

  // Consume one credit per joining player; leftover coin credit kept as plays
  function automatic logic [2:0] take(input logic [2:0] cr, input logic [2:0] n);
    take = (cr > n) ? cr - n : 3'h0;
  endfunction

  always_comb
  begin
    st_d     = st_q;
    coins_d  = coins_q;
    plays_d  = plays_q;
    frz_d    = frz_q;
    hum_d    = hum_q;
    mb_d     = mb_q;
    mw_d     = mw_q;
    refill_d = refill_q;
    bbusy_d  = bbusy_q;
    sc_d     = sc_q;
    hs_d     = hs_q;
    if (coin_ev && coins_q < MAX_COINS && st_q != ST_PLAY)
      coins_d = coins_q + 3'h1;
    case (st_q)
      ST_ATTRACT:
        if (coins_d != 3'h0 || cost_sel == COST_FREE) st_d = ST_READY;
      // A start press with no credit held is refused
      ST_READY:
        if ((sb_ev || sw_ev) && cred != 3'h0)
        begin
          hum_d = {sw_ev, sb_ev};
          if (cred >= 3'h2 && !(sb_ev && sw_ev))
          begin
            st_d  = ST_FREEZE;
            frz_d = 27'h0;
          end
          else
          begin
            st_d  = ST_PLAY;
            if (cred < 3'h2) hum_d = sb_ev ? 2'h1 : 2'h2; // One credit, one player; black wins a tie
            plays_d = take(cred, (hum_d == 2'h3) ? 3'h2 : 3'h1);
            coins_d = 3'h0;
          end
        end
      ST_FREEZE:
      begin
        frz_d = frz_q + 27'h1;
        if ((hum_q[0] & sw_ev) | (hum_q[1] & sb_ev))
        begin
          hum_d   = 2'h3;
          st_d    = ST_PLAY;
          plays_d = take(cred, 3'h2);
          coins_d = 3'h0;
        end
        else if (frz_q == 27'(FREEZE_CYCLES - 1))
        begin
          st_d    = ST_PLAY;
          plays_d = take(cred, 3'h1);
          coins_d = 3'h0;
        end
      end
      ST_PLAY:
      begin
        bbusy_d = (bbusy_q | (fire & ~bbusy_q)) & ~bomb_done;
        if (miss_evt[0] && mb_q != 3'h0) mb_d = mb_q - 3'h1;
        if (miss_evt[1] && mw_q != 3'h0) mw_d = mw_q - 3'h1;
        for (int i = 0; i < 2; i++)
          if (score_inc[i]) sc_d[i] = sc_q[i] + 16'h0001;
        if (|(field_clear & hum_q) && refill_q < MAX_REFILLS)
          refill_d = refill_q + 3'h1;
        if (done_b && done_w)
        begin
          for (int i = 0; i < 2; i++)
            if (sc_q[i] > hs_q[i]) hs_d[i] = sc_q[i];
          st_d = (cred != 3'h0) ? ST_READY : ST_ATTRACT;
        end
      end
      default: st_d = ST_ATTRACT;
    endcase
    if (st_q != ST_PLAY && st_d == ST_PLAY)
    begin
      mb_d     = miss_limit;
      mw_d     = miss_limit;
      refill_d = 3'h0;
      bbusy_d  = 2'h0;
      sc_d[0]  = SCORE_RST;
      sc_d[1]  = SCORE_RST;
    end
    if (hs_ev)
    begin
      hs_d[0] = SCORE_RST;
      hs_d[1] = SCORE_RST;
    end
  end

  // Registered outputs derived from next values (bomb_go from present ones) so each is a flip-flop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q         <= ST_ATTRACT;
      coins_q      <= 3'h0;
      plays_q      <= 3'h0;
      frz_q        <= 27'h0;
      hum_q        <= 2'h0;
      mb_q         <= 3'h0;
      mw_q         <= 3'h0;
      refill_q     <= 3'h0;
      bbusy_q      <= 2'h0;
      sc_q[0]      <= SCORE_RST;
      sc_q[1]      <= SCORE_RST;
      hs_q[0]      <= SCORE_RST;
      hs_q[1]      <= SCORE_RST;
      lockout_coil <= 1'b1;
      start_lamp   <= 1'b0;
      credits      <= 3'h0;
      mode         <= 2'h0;
      human        <= 2'h0;
      bomb_go      <= 2'h0;
      refill       <= 1'b0;
      show_misses  <= 1'b0;
      misses_left  <= 6'h00;
      scores       <= 32'h0000_0000;
      high_scores  <= 32'h0000_0000;
    end
    else
    begin
      st_q         <= st_d;
      coins_q      <= coins_d;
      plays_q      <= plays_d;
      frz_q        <= frz_d;
      hum_q        <= hum_d;
      mb_q         <= mb_d;
      mw_q         <= mw_d;
      refill_q     <= refill_d;
      bbusy_q      <= bbusy_d;
      sc_q         <= sc_d;
      hs_q         <= hs_d;
      lockout_coil <= (st_d == ST_ATTRACT);
      start_lamp   <= (st_d == ST_READY);
      credits      <= credit_of(coins_d, cost_sel, plays_d);
      mode         <= st_d;
      human        <= hum_d;
      bomb_go      <= (st_q == ST_PLAY) ? (fire & ~bbusy_q) : 2'h0;
      refill       <= (refill_d != refill_q);
      show_misses  <= (st_d == ST_PLAY);
      misses_left  <= {mw_d, mb_d};
      scores       <= {sc_d[1], sc_d[0]};
      high_scores  <= {hs_d[1], hs_d[0]};
    end
  end

  // Checks
  coil_attract_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_ATTRACT |-> lockout_coil) else $error("coil off in attract");
  lamp_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_lamp == (st_q == ST_READY) && !(lockout_coil && st_q == ST_PLAY))
    else $error("lamp or coil wrong");
  coin_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    coins_q <= MAX_COINS) else $error("coins above four");
  slam_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    slam && st_q != ST_PLAY |=> coins_q <= $past(coins_q)) else $error("coin under slam");
  refill_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refill_q <= MAX_REFILLS) else $error("too many refills");
  bomb_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bomb_go[0] |-> !$past(bbusy_q[0]) ##1 !bomb_go[0]) else $error("bomb reissued");
  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_FREEZE && frz_q != 27'(FREEZE_CYCLES - 1) && !sb_ev && !sw_ev
    |=> st_q == ST_FREEZE) else $error("freeze left early");
  freeze_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_FREEZE && frz_q == 27'(FREEZE_CYCLES - 1) |=> st_q == ST_PLAY)
    else $error("freeze did not end");
  no_credit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_READY && cred == 3'h0 |=> st_q == ST_READY) else $error("start without credit");
  one_credit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_READY && cred == 3'h1 && st_d == ST_PLAY |=> human != 2'h3)
    else $error("two players on one credit");
  miss_show_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    show_misses == (st_q == ST_PLAY)) else $error("miss display mismatch");
  hs_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hs_ev |=> ##1 high_scores == 32'h0000_0000) else $error("high score not cleared");
  two_player_c: cover property (@(posedge sys_clk) st_q == ST_FREEZE ##1 hum_q == 2'h3);
  freeze_exp_c: cover property (@(posedge sys_clk) st_q == ST_FREEZE ##1 st_q == ST_PLAY);
  game_end_c: cover property (@(posedge sys_clk) st_q == ST_PLAY ##1 st_q == ST_READY);
endmodule

//--- rtl/ccs_pkg.sv
// Package with constants and types for the coin, credit and start controller
package ccs_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          FREEZE_S        = 4;
  localparam int          FREEZE_CYC      = FREEZE_S * CLK_HZ;
  localparam int          DEB_CYC         = 8;
  localparam logic [2:0]  MAX_COINS       = 3'h4;
  localparam logic [2:0]  MAX_REFILLS     = 3'h4;
  localparam logic [15:0] SCORE_RST       = 16'h0000;
  localparam logic [1:0]  COST_ONE_COIN   = 2'h0;
  localparam logic [1:0]  COST_TWO_COIN   = 2'h1;
  localparam logic [1:0]  COST_TWO_PLAYER = 2'h2;
  localparam logic [1:0]  COST_FREE       = 2'h3;
  typedef enum logic [1:0] {ST_ATTRACT, ST_READY, ST_FREEZE, ST_PLAY} ccs_state_t;
endpackage

//--- tb/ccs_cab.sv
// Cabinet-side model: bomb fall and burst timing for each aircraft
`timescale 1ns/1ps
module ccs_cab #(
  parameter int FALL_CYC = 40
)(
  input  wire logic       sys_clk,   // System clock
  input  wire logic       rst_n,     // Synchronous reset, active low
  input  wire logic [1:0] bomb_go,   // Bomb release pulse per aircraft
  output logic      [1:0] bomb_done  // Landed and exploded pulse
);
  int cnt [2];

  // A bomb bursts a fixed time after release; a slow fall exposes early re-release
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      bomb_done[i] <= 1'b0;
      if (!rst_n)
        cnt[i] <= 0;
      else if (cnt[i] > 0)
      begin
        cnt[i] <= cnt[i] - 1;
        bomb_done[i] <= (cnt[i] == 1);
      end
      else if (bomb_go[i])
        cnt[i] <= FALL_CYC;
    end
  end
endmodule

//--- tb/ccs_ctrl_tb.sv
// Self-checking bench for the coin, credit and start controller
`timescale 1ns/1ps
module ccs_ctrl_tb;
  localparam int FRZ = 200;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        coin_a = 1'b0, coin_b = 1'b0, slam = 1'b0, hs_clear = 1'b0;
  logic        start_blk = 1'b0, start_wht = 1'b0;
  logic [1:0]  cost_sel = 2'h0;
  logic [1:0]  fire = 2'h0, miss_evt = 2'h0, field_clear = 2'h0, score_inc = 2'h0;
  logic        lockout_coil, start_lamp, refill, show_misses;
  logic [2:0]  credits;
  logic [1:0]  mode, human, bomb_go, bomb_done;
  logic [5:0]  misses_left;
  logic [31:0] scores, high_scores;
  int          fails = 0, checks_done = 0, cyc = 0, refills = 0, drops = 0;

  ccs_ctrl #(.FREEZE_CYCLES(FRZ)) uut (
    .sys_clk, .rst_n, .coin_a, .coin_b, .slam, .start_blk, .start_wht,
    .cost_sel, .miss_limit(3'h3), .hs_clear, .fire, .bomb_done,
    .miss_evt, .field_clear, .score_inc, .lockout_coil, .start_lamp,
    .credits, .mode, .human, .bomb_go, .refill, .show_misses,
    .misses_left, .scores, .high_scores
  );

  ccs_cab cab (.sys_clk, .rst_n, .bomb_go, .bomb_done);

  always #25 sys_clk = ~sys_clk;

  // Tallies of one-cycle pulses, and a ceiling so a hang still ends the run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    refills <= refills + int'(refill);
    drops <= drops + int'(bomb_go[0]);
    if (cyc == 2000)
    begin
      fails = fails + 1;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One momentary closure, held well past the debounce time, then opened as long
  task automatic press(input int k);
    for (int v = 1; v >= 0; v--)
    begin
      case (k)
        0: coin_a <= v[0];
        1: coin_b <= v[0];
        2: start_blk <= v[0];
        3: start_wht <= v[0];
        default: hs_clear <= v[0];
      endcase
      wt(12);
    end
  endtask

  // n game-logic pulses: 0 miss, 1 field cleared, 2 score point
  task automatic pulse(input int k, input int b, input int n);
    repeat (n)
    begin
      case (k)
        0: miss_evt[b] <= 1'b1;
        1: field_clear[b] <= 1'b1;
        default: score_inc[b] <= 1'b1;
      endcase
      wt(1);
      miss_evt <= 2'h0;
      field_clear <= 2'h0;
      score_inc <= 2'h0;
      wt(3);
    end
  endtask

  task automatic t_reset();
    chk("coil", 1, lockout_coil);
    chk("mode", 0, mode);
    chk("scores", 0, scores);
    chk("high", 0, high_scores);
  endtask

  task automatic t_slam();
    slam <= 1'b1;
    wt(10);
    press(0);
    slam <= 1'b0;
    wt(10);
    chk("slam credits", 0, credits);
    chk("slam mode", 0, mode);
  endtask

  // Coins from both slots; the fifth must be refused
  task automatic t_coins();
    press(0);
    chk("credits 1", 1, credits);
    chk("mode ready", 1, mode);
    chk("coil ready", 0, lockout_coil);
    chk("lamp ready", 1, start_lamp);
    press(1);
    chk("credits 2", 2, credits);
    repeat (3) press(0);
    chk("credits max", 4, credits);
  endtask

  task automatic t_two();
    press(2);
    chk("freeze", 2, mode);
    press(3);
    chk("play", 3, mode);
    chk("human two", 3, human);
    chk("credits left", 2, credits);
    chk("lamp play", 0, start_lamp);
    chk("show misses", 1, show_misses);
  endtask

  // Fire held down; the partner bursts each bomb 40 cycles after release
  task automatic t_bomb();
    int n;
    n = drops;
    fire <= 2'h1;
    wt(20);
    chk("bomb first", n + 1, drops);
    wt(15);
    chk("bomb held", n + 1, drops);
    wt(30);
    chk("bomb again", n + 2, drops);
    fire <= 2'h0;
  endtask

  task automatic t_refill_end();
    int n;
    n = refills;
    pulse(1, 0, 5);
    chk("refills", n + 4, refills);
    chk("misses kept", 6'h1B, misses_left);
    pulse(2, 0, 2);
    pulse(0, 1, 3);
    chk("one alive", 3, mode);
    chk("misses white", 6'h03, misses_left);
    pulse(0, 0, 3);
    chk("end ready", 1, mode);
    chk("show high", 0, show_misses);
    chk("high", 2, high_scores);
    chk("last scores", 32'h0000_0002, scores);
  endtask

  // Freeze must still stand shortly before its end, then play as one player
  task automatic t_single();
    press(3);
    wt(FRZ - 24);
    chk("solo freeze", 2, mode);
    wt(24);
    chk("solo play", 3, mode);
    chk("solo white", 2, human);
    pulse(0, 1, 3);
    press(2);
    chk("instant play", 3, mode);
    chk("solo black", 1, human);
    pulse(0, 1, 3);
    chk("cpu out", 3, mode);
    pulse(0, 0, 3);
    chk("attract", 0, mode);
    chk("coil again", 1, lockout_coil);
    chk("high kept", 2, high_scores);
    press(4);
    chk("high clear", 0, high_scores);
  endtask

  // Other cost settings, and a start refused while no credit is held
  task automatic t_cost();
    cost_sel <= 2'h1;
    press(0);
    chk("two coin one", 0, credits);
    press(2);
    chk("no credit start", 1, mode);
    press(1);
    chk("two coin two", 1, credits);
    cost_sel <= 2'h2;
    wt(2);
    chk("two per coin", 4, credits);
    cost_sel <= 2'h3;
    wt(2);
    chk("free play", 2, credits);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios in game order
  initial
  begin
    wt(20);
    rst_n <= 1'b1;
    wt(2);
    t_reset();
    t_slam();
    t_coins();
    t_two();
    t_bomb();
    t_refill_end();
    t_single();
    t_cost();
    complete_run();
  end
endmodule
